// [design/acfr_consts.vh]
// register map and field layout of the channel fault configuration bank
// assumes byte-wide registers behind a plain strobe port, 25 MHz clock
`ifndef ACFR_CONSTS_VH
`define ACFR_CONSTS_VH

`define ACFR_ADDR_W          8
`define ACFR_DATA_W          8
`define ACFR_NUM_CH          8

`define ACFR_FAULT_CTRL_IDX  8'h04
`define ACFR_CH_SET_FIRST    8'h05
`define ACFR_CH_SET_LAST     8'h0c
`define ACFR_POS_STAT_IDX    8'h12
`define ACFR_NEG_STAT_IDX    8'h13
`define ACFR_IRQ_STAT_IDX    8'h20
`define ACFR_IRQ_EN_IDX      8'h21
`define ACFR_IRQ_CLR_IDX     8'h22

`define ACFR_FAULT_CTRL_RST  8'h00
`define ACFR_CH_SET_RST      8'h10
`define ACFR_STAT_RST        8'h00

`define ACFR_TH_MSB          7
`define ACFR_TH_LSB          5
`define ACFR_PD_BIT          7
`define ACFR_GAIN_MSB        6
`define ACFR_GAIN_LSB        4
`define ACFR_MUX_MSB         2
`define ACFR_MUX_LSB         0
`define ACFR_CH_SET_MASK     8'hf7

// threshold levels in tenths of a percent of full scale
`define ACFR_TH_W            10
`define ACFR_HI_0            10'h3b6
`define ACFR_HI_1            10'h39d
`define ACFR_HI_2            10'h384
`define ACFR_HI_3            10'h36b
`define ACFR_HI_4            10'h352
`define ACFR_HI_5            10'h320
`define ACFR_HI_6            10'h2ee
`define ACFR_HI_7            10'h2bc
`define ACFR_LO_0            10'h032
`define ACFR_LO_1            10'h04b
`define ACFR_LO_2            10'h064
`define ACFR_LO_3            10'h07d
`define ACFR_LO_4            10'h096
`define ACFR_LO_5            10'h0c8
`define ACFR_LO_6            10'h0fa
`define ACFR_LO_7            10'h12c

`endif

// [design/acfr_regs.v]
// fault threshold control, per-channel settings and fault status registers
// assumes a plain strobe register port and levels already synchronous
`include "acfr_consts.vh"

module acfr_regs #(
   parameter NUM_CH = `ACFR_NUM_CH,
   parameter TH_W   = `ACFR_TH_W
) (
   input  wire                     clock,
   input  wire                     rst,
   input  wire [`ACFR_ADDR_W-1:0]  addr,
   input  wire [`ACFR_DATA_W-1:0]  wdata,
   input  wire                     wr_en,
   input  wire                     rd_en,
   output reg  [`ACFR_DATA_W-1:0]  rdata,
   input  wire [NUM_CH*TH_W-1:0]   pos_level,
   input  wire [NUM_CH*TH_W-1:0]   neg_level,
   output reg  [NUM_CH-1:0]        channel_power_down,
   output reg  [NUM_CH*3-1:0]      amp_gain_select,
   output reg  [NUM_CH*3-1:0]      input_select,
   output reg  [2:0]               threshold_select,
   output reg  [TH_W-1:0]          hi_threshold,
   output reg  [TH_W-1:0]          lo_threshold,
   output reg                      irq
);

   reg  [2:0]              th_sel_reg;
   reg  [7:0]              ch_set_reg [0:NUM_CH-1];
   reg  [NUM_CH-1:0]       pos_flag_reg;
   reg  [NUM_CH-1:0]       neg_flag_reg;
   reg  [1:0]              irq_stat_reg;
   reg  [1:0]              irq_en_reg;
   reg  [TH_W-1:0]         hi_th_next;
   reg  [TH_W-1:0]         lo_th_next;
   reg  [`ACFR_DATA_W-1:0] rdata_next;
   wire [NUM_CH-1:0]       pos_flag;
   wire [NUM_CH-1:0]       neg_flag;
   wire                    ch_hit;
   wire [`ACFR_ADDR_W-1:0] ch_idx;
   wire [1:0]              irq_event;
   integer                 i;

   assign ch_hit = (addr >= `ACFR_CH_SET_FIRST) && (addr <= `ACFR_CH_SET_LAST);
   assign ch_idx = addr - `ACFR_CH_SET_FIRST;

   // threshold pair decode
   always @* begin
      case (th_sel_reg)
         3'h0: begin hi_th_next = `ACFR_HI_0; lo_th_next = `ACFR_LO_0; end
         3'h1: begin hi_th_next = `ACFR_HI_1; lo_th_next = `ACFR_LO_1; end
         3'h2: begin hi_th_next = `ACFR_HI_2; lo_th_next = `ACFR_LO_2; end
         3'h3: begin hi_th_next = `ACFR_HI_3; lo_th_next = `ACFR_LO_3; end
         3'h4: begin hi_th_next = `ACFR_HI_4; lo_th_next = `ACFR_LO_4; end
         3'h5: begin hi_th_next = `ACFR_HI_5; lo_th_next = `ACFR_LO_5; end
         3'h6: begin hi_th_next = `ACFR_HI_6; lo_th_next = `ACFR_LO_6; end
         default: begin hi_th_next = `ACFR_HI_7; lo_th_next = `ACFR_LO_7; end
      endcase
   end

   // a powered-down channel reports no fault
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g = g + 1) begin : g_cmp
         acfr_threshold_cmp #(.TH_W(TH_W)) u_pos (
            .level   (pos_level[g*TH_W +: TH_W]),
            .hi_th   (hi_threshold),
            .lo_th   (lo_threshold),
            .enable  (~ch_set_reg[g][`ACFR_PD_BIT]),
            .exceeds (pos_flag[g])
         );
         acfr_threshold_cmp #(.TH_W(TH_W)) u_neg (
            .level   (neg_level[g*TH_W +: TH_W]),
            .hi_th   (hi_threshold),
            .lo_th   (lo_threshold),
            .enable  (~ch_set_reg[g][`ACFR_PD_BIT]),
            .exceeds (neg_flag[g])
         );
      end
   endgenerate

   // event: any flag rising in either status register
   assign irq_event = {|(neg_flag & ~neg_flag_reg), |(pos_flag & ~pos_flag_reg)};

   always @* begin
      rdata_next = 8'h00;
      if (addr == `ACFR_FAULT_CTRL_IDX)
         rdata_next = {th_sel_reg, 5'h00};
      else if (ch_hit)
         rdata_next = ch_set_reg[ch_idx[2:0]] & `ACFR_CH_SET_MASK;
      else if (addr == `ACFR_POS_STAT_IDX)
         rdata_next = pos_flag_reg;
      else if (addr == `ACFR_NEG_STAT_IDX)
         rdata_next = neg_flag_reg;
      else if (addr == `ACFR_IRQ_STAT_IDX)
         rdata_next = {6'h00, irq_stat_reg};
      else if (addr == `ACFR_IRQ_EN_IDX)
         rdata_next = {6'h00, irq_en_reg};
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         th_sel_reg   <= 3'h0;
         for (i = 0; i < NUM_CH; i = i + 1)
            ch_set_reg[i] <= `ACFR_CH_SET_RST;
         pos_flag_reg <= {NUM_CH{1'b0}};
         neg_flag_reg <= {NUM_CH{1'b0}};
         irq_stat_reg <= 2'h0;
         irq_en_reg   <= 2'h0;
         rdata        <= 8'h00;
         irq          <= 1'b0;
         hi_threshold <= `ACFR_HI_0;
         lo_threshold <= `ACFR_LO_0;
         threshold_select   <= 3'h0;
         channel_power_down <= {NUM_CH{1'b0}};
         amp_gain_select    <= {NUM_CH{3'h1}};
         input_select       <= {NUM_CH*3{1'b0}};
      end else begin
         // status tracks comparators; writes to 12h/13h fall through
         pos_flag_reg <= pos_flag;
         neg_flag_reg <= neg_flag;
         hi_threshold <= hi_th_next;
         lo_threshold <= lo_th_next;
         threshold_select <= th_sel_reg;
         if (wr_en) begin
            if (addr == `ACFR_FAULT_CTRL_IDX)
               th_sel_reg <= wdata[`ACFR_TH_MSB:`ACFR_TH_LSB];
            else if (ch_hit)
               ch_set_reg[ch_idx[2:0]] <= wdata & `ACFR_CH_SET_MASK;
            else if (addr == `ACFR_IRQ_EN_IDX)
               irq_en_reg <= wdata[1:0];
         end
         // set wins over a clear in the same cycle
         if (wr_en && addr == `ACFR_IRQ_CLR_IDX)
            irq_stat_reg <= (irq_stat_reg & ~wdata[1:0]) | irq_event;
         else
            irq_stat_reg <= irq_stat_reg | irq_event;
         irq <= |(irq_stat_reg & irq_en_reg);
         rdata <= rd_en ? rdata_next : 8'h00;
         for (i = 0; i < NUM_CH; i = i + 1) begin
            channel_power_down[i]   <= ch_set_reg[i][`ACFR_PD_BIT];
            amp_gain_select[i*3 +: 3] <= ch_set_reg[i][`ACFR_GAIN_MSB:`ACFR_GAIN_LSB];
            input_select[i*3 +: 3]  <= ch_set_reg[i][`ACFR_MUX_MSB:`ACFR_MUX_LSB];
         end
      end
   end

endmodule // acfr_regs

// [design/acfr_threshold_cmp.v]
// one input pin compared against the selected threshold pair
// assumes level is a sampled input in tenths of a percent of full scale
`include "acfr_consts.vh"

module acfr_threshold_cmp #(
   parameter TH_W = `ACFR_TH_W
) (
   input  wire [TH_W-1:0] level,
   input  wire [TH_W-1:0] hi_th,
   input  wire [TH_W-1:0] lo_th,
   input  wire            enable,
   output wire            exceeds
);
   // out of range on either side counts as exceeding the window
   assign exceeds = enable & ((level > hi_th) | (level < lo_th));
endmodule // acfr_threshold_cmp

// [verif/acfr_regs_monitor.sv]
// checker for the fault configuration register bank
// assumes a bind onto acfr_regs, one clock, async active-high reset
module acfr_regs_monitor #(
   parameter NUM_CH = 8,
   parameter TH_W   = 10
) (
   input wire logic                clock,
   input wire logic                rst,
   input wire logic [7:0]          addr,
   input wire logic [7:0]          wdata,
   input wire logic                wr_en,
   input wire logic                rd_en,
   input wire logic [7:0]          rdata,
   input wire logic [NUM_CH-1:0]   channel_power_down,
   input wire logic [NUM_CH*3-1:0] amp_gain_select,
   input wire logic [NUM_CH*3-1:0] input_select,
   input wire logic [2:0]          threshold_select,
   input wire logic [TH_W-1:0]     hi_threshold,
   input wire logic [TH_W-1:0]     lo_threshold
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);
   chk_rd_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
      else $error("read data not idle");
   chk_th_write: assert property (wr_en && addr == 8'h04 |-> ##2
      {threshold_select, 5'h00} == ($past(wdata, 2) & 8'he0)) else $error("select lost");
   chk_pd_write: assert property (wr_en && addr == 8'h05 |-> ##2
      {channel_power_down[0], 7'h00} == ($past(wdata, 2) & 8'h80)) else $error("pd lost");
   chk_last_ch: assert property (wr_en && addr == 8'h0c |-> ##2 {1'b0, amp_gain_select[23:21],
      1'b0, input_select[23:21]} == ($past(wdata, 2) & 8'h77)) else $error("ch8 lost");
   chk_code_zero: assert property (threshold_select == 3'h0 |->
      hi_threshold == 10'h3b6 && lo_threshold == 10'h032) else $error("code 0 pair");
   chk_code_four: assert property (threshold_select == 3'h4 |->
      hi_threshold == 10'h352 && lo_threshold == 10'h096) else $error("code 4 pair");
   chk_ctrl_read: assert property (rd_en && addr == 8'h04 |=>
      rdata == {threshold_select, 5'h00}) else $error("ctrl read");
   chk_ch_read: assert property (rd_en && addr == 8'h05 |=> rdata == {channel_power_down[0],
      amp_gain_select[2:0], 1'b0, input_select[2:0]}) else $error("ch1 read");
   chk_unmapped: assert property (rd_en && addr == 8'h0d |=> rdata == 8'h00)
      else $error("unmapped read");
   cover property (wr_en && addr == 8'h04);
   cover property (rd_en && addr == 8'h12 ##1 rdata != 8'h00);
   cover property (threshold_select == 3'h7);
endmodule // acfr_regs_monitor

// [verif/tb_adc_channel_fault_config_regs.sv]
// self-checking bench for the fault configuration register bank
// assumes acfr_regs with default parameters and a 25 MHz clock
module tb_adc_channel_fault_config_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock = 0, rst = 1, wr_en = 0, rd_en = 0, irq;
   logic [7:0]  addr = 0, wdata = 0, rdata;
   logic [79:0] pos_level = {8{10'h1f4}}, neg_level = {8{10'h1f4}};
   logic [23:0] amp_gain_select, input_select;
   logic [9:0]  hi_threshold, lo_threshold;
   logic [7:0]  channel_power_down;
   logic [2:0]  threshold_select;
   int          mismatches = 0, checks_done = 0;
   logic [9:0]  hi_t [8] = '{10'h3b6, 10'h39d, 10'h384, 10'h36b, 10'h352, 10'h320, 10'h2ee, 10'h2bc};
   logic [9:0]  lo_t [8] = '{10'h032, 10'h04b, 10'h064, 10'h07d, 10'h096, 10'h0c8, 10'h0fa, 10'h12c};
   logic [2:0]  gn [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
   logic [2:0]  mx [5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
   acfr_regs dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .pos_level(pos_level), .neg_level(neg_level),
      .channel_power_down(channel_power_down), .amp_gain_select(amp_gain_select),
      .input_select(input_select), .threshold_select(threshold_select),
      .hi_threshold(hi_threshold), .lo_threshold(lo_threshold), .irq(irq));
   initial forever #20 clock = ~clock;
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_en <= 1;
      @(posedge clock);
      wr_en <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      rd_en <= 1;
      @(posedge clock);
      rd_en <= 0;
      #1 chk({2'h0, rdata}, {2'h0, d});
   endtask
   // outputs land one edge after the write edge
   task automatic settle;
      repeat (3) @(posedge clock);
      #1;
   endtask
   task automatic lv(input int n, input logic [9:0] p, input logic [9:0] q);
      @(posedge clock);
      pos_level[n*10+:10] <= p;
      neg_level[n*10+:10] <= q;
   endtask
   task automatic t_reset;
      rd(8'h04, 8'h00);
      for (int i = 5; i < 13; i++) rd(i[7:0], 8'h10);
      rd(8'h12, 8'h00);
      rd(8'h13, 8'h00);
      rd(8'h0d, 8'h00);
   endtask
   task automatic t_thresh;
      for (int c = 0; c < 8; c++) begin
         wr(8'h04, {c[2:0], 5'h00});
         rd(8'h04, {c[2:0], 5'h00});
         settle();
         chk(hi_threshold, hi_t[c]);
         chk(lo_threshold, lo_t[c]);
      end
   endtask
   task automatic t_chan;
      for (int c = 0; c < 8; c++) begin
         wr(8'h05 + c[7:0], {1'b1, gn[c % 5], 1'b0, mx[c % 5]});
         rd(8'h05 + c[7:0], {1'b1, gn[c % 5], 1'b0, mx[c % 5]});
         settle();
         chk({9'h0, channel_power_down[c]}, 10'h001);
         chk({7'h0, amp_gain_select[c*3+:3]}, {7'h0, gn[c % 5]});
         chk({7'h0, input_select[c*3+:3]}, {7'h0, mx[c % 5]});
         wr(8'h05 + c[7:0], 8'h10);
      end
   endtask
   task automatic t_status;
      wr(8'h04, 8'h00);
      lv(0, 10'h3c0, 10'h1f4);
      lv(7, 10'h1f4, 10'h028);
      settle();
      rd(8'h12, 8'h01);
      rd(8'h13, 8'h80);
      wr(8'h12, 8'h00);
      rd(8'h12, 8'h01);
      chk({9'h0, irq}, 10'h000);
      wr(8'h21, 8'h03);
      settle();
      chk({9'h0, irq}, 10'h001);
      rd(8'h20, 8'h03);
      wr(8'h22, 8'h03);
      settle();
      chk({9'h0, irq}, 10'h000);
      // 800 lies under the 95 percent side but over the 70 percent side
      lv(7, 10'h320, 10'h1f4);
      settle();
      rd(8'h13, 8'h00);
      rd(8'h12, 8'h01);
      wr(8'h04, 8'he0);
      settle();
      rd(8'h12, 8'h81);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clock);
      rst <= 0;
      t_reset();
      t_thresh();
      t_chan();
      t_status();
      stop_test();
   end
endmodule // tb_adc_channel_fault_config_regs
bind acfr_regs acfr_regs_monitor #(.NUM_CH(NUM_CH), .TH_W(TH_W)) mon (.clock(clock), .rst(rst),
   .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
   .channel_power_down(channel_power_down), .amp_gain_select(amp_gain_select),
   .input_select(input_select), .threshold_select(threshold_select),
   .hi_threshold(hi_threshold), .lo_threshold(lo_threshold));
